// ---- pesb_regs.svh ----
// Event codes, unit masks and timing counts for the stall and branch event selector
// Notes on behaviour
// - DCH/04 counts load, store, commit-wait stall cycles
// - Load stall from load capacity until load retires
// - Store stall from store capacity until store commits
// - Commit wait while fence holds for older stores
// - DCH/08H counts FP control word stall cycles
// - DCH/10H counts mispredict detect until retire
// - Block micro-op entry during mispredict clear
// - DCH/1FH counts cycles with any stall
// - Decoded-branch event counts each decoded branch
// - E4H counts falsely detected taken branches
// - False branch also raises a resteer
// - E6H counts front-end resteers
// - Each resteer stalls fetch about seven cycles
// - F0/00H counts ascending L2 prefetches
// - F8/00H counts descending L2 prefetches
// - Issued prefetch never cancelled, line filled
// - DCH/01H counts reorder buffer full cycles
// - DCH/02H counts reservation station full cycles
`ifndef PESB_REGS_SVH
`define PESB_REGS_SVH
`define PESB_EV_STALL 8'hdc
`define PESB_EV_DEC_BR 8'he0
`define PESB_EV_FALSE_BR 8'he4
`define PESB_EV_RESTEER 8'he6
`define PESB_EV_PF_UP 8'hf0
`define PESB_EV_PF_DN 8'hf8
`define PESB_UM_NONE 8'h00
`define PESB_UM_ROB 8'h01
`define PESB_UM_RS 8'h02
`define PESB_UM_LDST 8'h04
`define PESB_UM_FPCW 8'h08
`define PESB_UM_BRCLR 8'h10
`define PESB_UM_ANY 8'h1f
`define PESB_RESTEER_CYCLES 7
`endif

// ---- pesb_pkg.sv ----
// Types shared by the event selector modules
package pesb_pkg;
  // Clear tracker states
  typedef enum logic [1:0] {
    PESB_CLR_IDLE = 2'b01,
    PESB_CLR_BUSY = 2'b10
  } pesb_clr_e;
  typedef logic [7:0] pesb_code_t;
endpackage

// ---- pesb_cond_if.sv ----
// Condition strobes passed from the stall tracker to the selector core
`timescale 1ns/1ns
interface pesb_cond_if;
  logic ld_stall;
  logic st_stall;
  logic commit_wait;
  logic clr_stall;
  modport src (output ld_stall, output st_stall, output commit_wait, output clr_stall);
  modport dst (input ld_stall, input st_stall, input commit_wait, input clr_stall);
endinterface

// ---- pesb_stall_track.sv ----
// Tracks load, store, commit-wait and mispredict-clear stall conditions
`timescale 1ns/1ns
`include "pesb_regs.svh"
module pesb_stall_track
  import pesb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Pipeline events
  input wire logic ld_full_i,
  input wire logic ld_retire_i,
  input wire logic st_full_i,
  input wire logic st_commit_i,
  input wire logic fence_wait_i,
  input wire logic mispredict_i,
  input wire logic clr_retired_i,
  // Blocks micro-op entry
  output logic uop_block_o,
  // Conditions out
  pesb_cond_if.src cond
);
  logic ld_stall; // Load limit stall held
  logic st_stall; // Store limit stall held
  pesb_clr_e clr_state; // Mispredict clear tracker
  pesb_clr_e next_clr_state;
  wire logic next_ld_stall;
  wire logic next_st_stall;
  ////////////////////////////////////////////////////////////////////////
  // load stall sets, retire ends
  // Set wins over retire in the same cycle, capacity still reached
  assign next_ld_stall = ld_full_i | (ld_stall & ~ld_retire_i);
  assign next_st_stall = st_full_i | (st_stall & ~st_commit_i);
  // Clear interval tracker
  always_comb begin
    next_clr_state = clr_state;
    unique case (clr_state)
      // Waiting for a detected mispredict
      PESB_CLR_IDLE: begin
        if (mispredict_i) begin
          next_clr_state = PESB_CLR_BUSY;
        end
      end
      // Until branch and older micro-ops retire
      PESB_CLR_BUSY: begin
        if (clr_retired_i & ~mispredict_i) begin
          next_clr_state = PESB_CLR_IDLE;
        end
      end
      default: begin
        next_clr_state = PESB_CLR_IDLE;
      end
    endcase
  end
  // State registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ld_stall <= 1'b0;
      st_stall <= 1'b0;
      clr_state <= PESB_CLR_IDLE;
    end else if (en_i) begin
      ld_stall <= next_ld_stall;
      st_stall <= next_st_stall;
      clr_state <= next_clr_state;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // cycles from detection to retire
  assign cond.clr_stall = (clr_state == PESB_CLR_BUSY);
  assign cond.ld_stall = ld_stall;
  assign cond.st_stall = st_stall;
  // commit wait is a live level
  assign cond.commit_wait = fence_wait_i;
  assign uop_block_o = (clr_state == PESB_CLR_BUSY);
endmodule

// ---- pesb_fetch_stall.sv ----
// Holds fetch stalled for a fixed number of cycles after each resteer
`timescale 1ns/1ns
`include "pesb_regs.svh"
module pesb_fetch_stall
  import pesb_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = `PESB_RESTEER_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Resteer strobe
  input wire logic resteer_i,
  // Fetch stall level
  output logic stall_o
);
  localparam int unsigned CW = $clog2(STALL_CYCLES + 1);
  logic [CW-1:0] remain; // Cycles of stall still owed
  wire logic [CW-1:0] next_remain;
  // Refuse a zero penalty at elaboration; the timer could never stand
  if (STALL_CYCLES < 1) begin : g_bad_cycles
    $error("STALL_CYCLES must be at least one");
  end
  ////////////////////////////////////////////////////////////////////////
  // reload on each resteer
  // A resteer during a stall restarts the full penalty
  assign next_remain = resteer_i ? CW'(STALL_CYCLES) : (remain != '0) ? remain - CW'(1) : remain;
  // Countdown register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      remain <= '0;
    end else if (en_i) begin
      remain <= next_remain;
    end
  end
  assign stall_o = (remain != '0);
endmodule

// ---- pesb_top.sv ----
// Event selector for one performance counter: stalls, branches, prefetches
`timescale 1ns/1ns
`include "pesb_regs.svh"
module pesb_top
  import pesb_pkg::*;
#(
  parameter int unsigned COUNT_W = 40,
  parameter int unsigned RESTEER_CYCLES = `PESB_RESTEER_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Event selection
  input wire logic [7:0] event_code_i,
  input wire logic [7:0] unit_mask_i,
  // Stall sources
  input wire logic rob_full_i,
  input wire logic rs_full_i,
  input wire logic ld_full_i,
  input wire logic ld_retire_i,
  input wire logic st_full_i,
  input wire logic st_commit_i,
  input wire logic fence_wait_i,
  input wire logic fpcw_stall_i,
  input wire logic mispredict_i,
  input wire logic clr_retired_i,
  // Front end events
  input wire logic branch_decoded_i,
  input wire logic false_branch_i,
  input wire logic resteer_i,
  // Data prefetcher requests
  input wire logic pf_up_issue_i,
  input wire logic pf_dn_issue_i,
  // Counter control
  input wire logic count_clear_i,
  // Results
  output logic [COUNT_W-1:0] count_o,
  output logic step_o,
  output logic uop_block_o,
  output logic fetch_stall_o,
  output logic resteer_o,
  output logic pf_up_fill_o,
  output logic pf_dn_fill_o
);
  // Refuse counter widths the logic cannot serve, at elaboration
  if (COUNT_W < 8 || COUNT_W > 64) begin : g_bad_width
    $error("COUNT_W must lie in 8..64");
  end
  ////////////////////////////////////////////////////////////////////////
  // Exact pair compare
  function automatic logic sel_is(input pesb_code_t code, input pesb_code_t mask,
                                  input pesb_code_t want_code, input pesb_code_t want_mask);
    sel_is = (code == want_code) && (mask == want_mask);
  endfunction
  pesb_cond_if cond_bus();
  // Stall tracking
  pesb_stall_track u_track (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(en_i),
    .ld_full_i(ld_full_i),
    .ld_retire_i(ld_retire_i),
    .st_full_i(st_full_i),
    .st_commit_i(st_commit_i),
    .fence_wait_i(fence_wait_i),
    .mispredict_i(mispredict_i),
    .clr_retired_i(clr_retired_i),
    .uop_block_o(uop_block_o),
    .cond(cond_bus.src)
  );
  // Resteer sources merge
  wire logic any_resteer;
  assign any_resteer = resteer_i | false_branch_i;
  assign resteer_o = any_resteer;
  // Fetch penalty timer
  pesb_fetch_stall #(.STALL_CYCLES(RESTEER_CYCLES)) u_fetch (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(en_i),
    .resteer_i(any_resteer),
    .stall_o(fetch_stall_o)
  );
  ////////////////////////////////////////////////////////////////////////
  // Condition decode
  wire logic ldst_cond;
  wire logic any_stall;
  assign ldst_cond = cond_bus.ld_stall | cond_bus.st_stall | cond_bus.commit_wait;
  assign any_stall = rob_full_i | rs_full_i | ldst_cond | fpcw_stall_i | cond_bus.clr_stall;
  // Selection matches
  wire logic m_rob, m_rs, m_ldst, m_fpcw, m_brclr, m_any;
  wire logic m_dec, m_false, m_rest, m_up, m_dn;
  assign m_rob = sel_is(event_code_i, unit_mask_i, `PESB_EV_STALL, `PESB_UM_ROB);
  assign m_rs = sel_is(event_code_i, unit_mask_i, `PESB_EV_STALL, `PESB_UM_RS);
  assign m_ldst = sel_is(event_code_i, unit_mask_i, `PESB_EV_STALL, `PESB_UM_LDST);
  assign m_fpcw = sel_is(event_code_i, unit_mask_i, `PESB_EV_STALL, `PESB_UM_FPCW);
  assign m_brclr = sel_is(event_code_i, unit_mask_i, `PESB_EV_STALL, `PESB_UM_BRCLR);
  assign m_any = sel_is(event_code_i, unit_mask_i, `PESB_EV_STALL, `PESB_UM_ANY);
  assign m_dec = sel_is(event_code_i, unit_mask_i, `PESB_EV_DEC_BR, `PESB_UM_NONE);
  assign m_false = sel_is(event_code_i, unit_mask_i, `PESB_EV_FALSE_BR, `PESB_UM_NONE);
  assign m_rest = sel_is(event_code_i, unit_mask_i, `PESB_EV_RESTEER, `PESB_UM_NONE);
  assign m_up = sel_is(event_code_i, unit_mask_i, `PESB_EV_PF_UP, `PESB_UM_NONE);
  assign m_dn = sel_is(event_code_i, unit_mask_i, `PESB_EV_PF_DN, `PESB_UM_NONE);
  // Qualified step, one per cycle at most
  wire logic next_step;
  assign next_step = (m_rob & rob_full_i) | (m_rs & rs_full_i) | (m_ldst & ldst_cond)
                   | (m_fpcw & fpcw_stall_i) | (m_brclr & cond_bus.clr_stall) | (m_any & any_stall)
                   | (m_dec & branch_decoded_i) | (m_false & false_branch_i) | (m_rest & any_resteer)
                   | (m_up & pf_up_issue_i) | (m_dn & pf_dn_issue_i);
  ////////////////////////////////////////////////////////////////////////
  // Counter and prefetch fill registers
  logic [COUNT_W-1:0] count;
  logic step;
  logic pf_up_fill;
  logic pf_dn_fill;
  wire logic [COUNT_W-1:0] next_count;
  // Clear wins over a step; software asked for zero
  assign next_count = count_clear_i ? '0 : next_step ? count + COUNT_W'(1) : count;
  // Counter register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count <= '0;
      step <= 1'b0;
    end else if (en_i) begin
      count <= next_count;
      step <= next_step & ~count_clear_i;
    end
  end
  // issued prefetch always fills
  // No cancel input exists, so every issue becomes a fill request
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pf_up_fill <= 1'b0;
      pf_dn_fill <= 1'b0;
    end else if (en_i) begin
      pf_up_fill <= pf_up_issue_i;
      pf_dn_fill <= pf_dn_issue_i;
    end
  end
  assign count_o = count;
  assign step_o = step;
  assign pf_up_fill_o = pf_up_fill;
  assign pf_dn_fill_o = pf_dn_fill;
endmodule

// ---- pesb_pipe_model.sv ----
// Pipeline model that raises the selector's condition strobes
`timescale 1ns/1ns
module pesb_pipe_model (
  // Clock
  input wire logic clk_i,
  // Strobes asked for by the bench
  input wire logic [14:0] want_i,
  // Strobes shown to the selector
  output logic [14:0] ev_o
);
  // Quiet before the first edge
  initial ev_o = '0;
  // Launched just after the edge, so a strobe stands one full cycle
  always @(posedge clk_i) begin
    ev_o <= want_i;
  end
endmodule

// ---- pesb_top_chk.sv ----
// Concurrent checks on the event selector ports
`timescale 1ns/1ns
module pesb_top_chk #(
  parameter int unsigned COUNT_W = 40,
  parameter int unsigned RESTEER_CYCLES = 7
) (
  // Clock, reset, selection
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic [7:0] event_code_i,
  input wire logic [7:0] unit_mask_i,
  input wire logic count_clear_i,
  // Event sources
  input wire logic mispredict_i,
  input wire logic clr_retired_i,
  input wire logic branch_decoded_i,
  input wire logic false_branch_i,
  input wire logic resteer_i,
  input wire logic pf_up_issue_i,
  input wire logic pf_dn_issue_i,
  // Results
  input wire logic [COUNT_W-1:0] count_o,
  input wire logic step_o,
  input wire logic uop_block_o,
  input wire logic fetch_stall_o,
  input wire logic resteer_o,
  input wire logic pf_up_fill_o,
  input wire logic pf_dn_fill_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Edge at which a step may land; a clear wins over a step
  wire go = en_i && !count_clear_i;
  wire sel_dec = event_code_i == 8'he0 && unit_mask_i == 8'h00;
  wire sel_false = event_code_i == 8'he4 && unit_mask_i == 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  a_step_adds_one: assert property (step_o && $past(go) |-> count_o == $past(count_o) + 1'b1)
    else $error("count did not follow step");
  a_decode_steps: assert property (go && sel_dec && branch_decoded_i |=> step_o)
    else $error("decoded branch not counted");
  a_false_steps: assert property (go && sel_false && false_branch_i |=> step_o)
    else $error("false branch not counted");
  a_resteer_follows: assert property (resteer_o == (resteer_i || false_branch_i))
    else $error("resteer output wrong");
  a_stall_starts: assert property (en_i && resteer_i |=> fetch_stall_o)
    else $error("fetch stall missing");
  a_stall_ends: assert property (en_i && resteer_i ##1 (en_i && !resteer_o)[*7] |->
    fetch_stall_o ##1 !fetch_stall_o) else $error("fetch stall wrong length");
  a_up_fills: assert property (en_i && pf_up_issue_i |=> pf_up_fill_o)
    else $error("upward prefetch not filled");
  a_dn_fills: assert property (en_i && pf_dn_issue_i |=> pf_dn_fill_o)
    else $error("downward prefetch not filled");
  a_block_sets: assert property (en_i && mispredict_i |=> uop_block_o)
    else $error("entry not blocked");
  a_block_clears: assert property (en_i && clr_retired_i && !mispredict_i |=> !uop_block_o)
    else $error("entry block not released");
  a_freeze_holds: assert property (!en_i |=> $stable(count_o))
    else $error("count moved while disabled");
  // Main scenarios reached
  c_step: cover property (step_o);
  c_block: cover property (uop_block_o ##1 !uop_block_o);
  c_stall: cover property (fetch_stall_o && step_o);
endmodule
bind pesb_top pesb_top_chk #(.COUNT_W(COUNT_W), .RESTEER_CYCLES(RESTEER_CYCLES)) u_chk (.*);

// ---- pesb_top_test.sv ----
// Self-checking bench for the event selector
`timescale 1ns/1ns
module pesb_top_test;
  typedef struct {logic [7:0] code; logic [7:0] mask; int bit_i; logic [39:0] exp;} pesb_row_s;
  logic clk_i, rst_b_i = 1'b0, en_i = 1'b1, count_clear_i = 1'b0;
  logic [7:0] event_code_i = 8'h00, unit_mask_i = 8'h00;
  logic [14:0] want = '0, ev;
  logic [39:0] count_o;
  logic step_o, uop_block_o, fetch_stall_o, resteer_o, pf_up_fill_o, pf_dn_fill_o;
  wire rob_full_i, rs_full_i, ld_full_i, ld_retire_i, st_full_i, st_commit_i, fence_wait_i, fpcw_stall_i;
  wire mispredict_i, clr_retired_i, branch_decoded_i, false_branch_i, resteer_i, pf_up_issue_i, pf_dn_issue_i;
  int err_count = 0, n_tests = 0, n;
  // Strobe bit order shared with the pipeline model
  assign {pf_dn_issue_i, pf_up_issue_i, resteer_i, false_branch_i, branch_decoded_i, clr_retired_i, mispredict_i,
    fpcw_stall_i, fence_wait_i, st_commit_i, st_full_i, ld_retire_i, ld_full_i, rs_full_i, rob_full_i} = ev;
  // Single strobes with the count they should leave
  pesb_row_s rows [14] = '{
    '{8'hdc, 8'h01, 0, 1}, '{8'hdc, 8'h02, 1, 1}, '{8'hdc, 8'h08, 7, 1}, '{8'hdc, 8'h04, 6, 1},
    '{8'hdc, 8'h1f, 0, 1}, '{8'hdc, 8'h1f, 7, 1}, '{8'he0, 8'h00, 10, 1}, '{8'he4, 8'h00, 11, 1},
    '{8'he6, 8'h00, 12, 1}, '{8'he6, 8'h00, 11, 1}, '{8'hf0, 8'h00, 13, 1}, '{8'hf8, 8'h00, 14, 1},
    '{8'hdc, 8'h01, 1, 0}, '{8'he0, 8'h01, 10, 0}};
  ////////////////////////////////////////////////////////////////////////////
  pesb_top #(.COUNT_W(40), .RESTEER_CYCLES(7)) uut (.*);
  pesb_pipe_model pipe (.clk_i(clk_i), .want_i(want), .ev_o(ev));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Select an event and zero the count
  task automatic pick(input logic [7:0] c, input logic [7:0] m);
    @(posedge clk_i);
    event_code_i <= c;
    unit_mask_i <= m;
    count_clear_i <= 1'b1;
    @(posedge clk_i);
    count_clear_i <= 1'b0;
  endtask
  // One-cycle strobe from the pipeline model
  task automatic pulse(input int b);
    @(posedge clk_i);
    want <= 15'h1 << b;
    @(posedge clk_i);
    want <= '0;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %0d", $time, what, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the roughly 165 cycles needed
  initial begin
    tick(3000);
    err_count++;
    report_and_stop();
  end
  initial begin
    tick(20);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      pick(rows[i].code, rows[i].mask);
      pulse(rows[i].bit_i);
      tick(1);
      @(negedge clk_i);
      chk(40'(step_o), rows[i].exp, "step pulse");
      chk(40'({pf_dn_fill_o, pf_up_fill_o}), 40'({rows[i].bit_i == 14, rows[i].bit_i == 13}), "prefetch fill");
      chk(count_o, rows[i].exp, "table row");
    end
    // Held stalls: set, five idle cycles, end strobe; six cycles counted
    for (int p = 0; p < 3; p++) begin
      pick(8'hdc, p == 2 ? 8'h10 : 8'h04);
      pulse(p == 2 ? 8 : 2 * p + 2);
      tick(4);
      if (p == 2) chk(40'(uop_block_o), 1, "block during clear");
      pulse(p == 2 ? 9 : 2 * p + 3);
      tick(3);
      chk(count_o, 6, "held stall length");
      chk(40'(uop_block_o), 0, "block after clear");
    end
    // Resteer holds fetch for seven cycles
    pick(8'he6, 8'h00);
    pulse(12);
    n = 0;
    @(negedge clk_i);
    chk(40'(resteer_o), 1, "resteer out");
    repeat (11) begin
      @(negedge clk_i);
      if (fetch_stall_o === 1'b1) n++;
    end
    chk(40'(n), 7, "fetch stall cycles");
    chk(count_o, 1, "resteer count");
    // Disabled counter ignores a held stall
    pick(8'hdc, 8'h1f);
    en_i <= 1'b0;
    want <= 15'h1;
    tick(4);
    want <= '0;
    tick(2);
    en_i <= 1'b1;
    tick(2);
    chk(count_o, 0, "frozen count");
    // Reset in mid-run zeroes the count
    pick(8'he0, 8'h00);
    pulse(10);
    tick(2);
    rst_b_i <= 1'b0;
    tick(2);
    rst_b_i <= 1'b1;
    tick(1);
    chk(count_o, 0, "count after reset");
    report_and_stop();
  end
endmodule
